// file: src/pllsc_top.sv
// Scan chain, active settings, output dividers and AHB-Lite registers.
// Assumes scan pins are asynchronous to hclk and toggle far slower.
`timescale 1ns/1ps
module pllsc_top
  import pllsc_pkg::*;
(
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [7:0]          haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic                hready,
  input  wire logic [31:0]         hwdata,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Scan pins from the controller
  input  wire pllsc_scan_t         scan_in,
  // Loop settings
  output logic      [CNT_W+1:0]    fb_div,
  output logic      [CNT_W+1:0]    ref_div,
  output logic      [SET_BITS-1:0] charge_pump,
  output logic      [SET_BITS-1:0] loop_filter,
  // Divided clocks, index is the output counter number
  output logic      [NUM_OUT-1:0]  div_clk
);

  // ==========================================================
  // Pin synchronisers, third stage only feeds edge detection
  pllsc_scan_t meta_r, sync_r, last_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= scan_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  logic ctrl_en_r;
  logic shift_ev, upd_ev, sw_upd, clr_done;
  assign shift_ev = ctrl_en_r & sync_r.ena & sync_r.clk & ~last_r.clk;
  assign upd_ev   = ctrl_en_r & sync_r.update & ~last_r.update;

  // ==========================================================
  // Shift chain and staged settings
  logic [CHAIN_LEN-1:0] chain_r, chain_nxt;
  pllsc_chain_t         active_r, active_nxt;
  logic [BCNT_W-1:0]    bcnt_r, bcnt_nxt;
  logic                 done_r, done_nxt;
  logic                 full, apply;

  assign full  = (bcnt_r == BCNT_W'(CHAIN_LEN));
  assign apply = (upd_ev | sw_upd) & full;

  always_comb begin
    chain_nxt  = chain_r;
    bcnt_nxt   = bcnt_r;
    active_nxt = active_r;
    done_nxt   = done_r;
    if (shift_ev) begin
      // New bits enter at the top, so the first one ends at bit 0
      chain_nxt = {sync_r.data, chain_r[CHAIN_LEN-1:1]};
      if (!full)
        bcnt_nxt = bcnt_r + 1'b1;
    end
    if (apply) begin
      // Partial loads never reach the active copy
      active_nxt = pllsc_chain_t'(chain_r);
      bcnt_nxt   = '0;
      done_nxt   = 1'b1;
    end else if (clr_done)
      done_nxt   = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain_r  <= '0;
      bcnt_r   <= '0;
      active_r <= ACTIVE_RST;
      done_r   <= 1'b0;
    end else begin
      chain_r  <= chain_nxt;
      bcnt_r   <= bcnt_nxt;
      active_r <= active_nxt;
      done_r   <= done_nxt;
    end
  end

  // ==========================================================
  // Loop setting outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_div      <= '0;
      ref_div     <= '0;
      charge_pump <= '0;
      loop_filter <= '0;
    end else begin
      fb_div      <= active_r.fb_div;
      ref_div     <= active_r.ref_div;
      charge_pump <= active_r.charge_pump;
      loop_filter <= active_r.loop_filter;
    end
  end

  // ==========================================================
  // Output dividers
  pllsc_ctr_t ctr [NUM_OUT];
  assign ctr[0] = active_r.output_counter_0;
  assign ctr[1] = active_r.output_counter_1;
  assign ctr[2] = active_r.output_counter_2;
  assign ctr[3] = active_r.output_counter_3;
  assign ctr[4] = active_r.output_counter_4;

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_div
      logic [HALF_W-1:0] cnt_r, cnt_nxt, len;
      logic              ph_r, ph_nxt, neg_r, q_r;
      // A zero count is taken as one cycle
      assign len = ph_r ? ((ctr[g].high == '0) ? 8'h01 : ctr[g].high)
                        : ((ctr[g].low  == '0) ? 8'h01 : ctr[g].low);
      always_comb begin
        cnt_nxt = cnt_r + 1'b1;
        ph_nxt  = ph_r;
        if (cnt_nxt >= len) begin
          cnt_nxt = '0;
          ph_nxt  = ~ph_r;
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_r <= '0;
          ph_r  <= 1'b0;
          q_r   <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          ph_r  <= ph_nxt;
          q_r   <= ph_nxt;
        end
      end
      // Half-cycle copy trims the high phase by 0.5 and pads the low
      always_ff @(negedge hclk or negedge hresetn) begin
        if (!hresetn)
          neg_r <= 1'b0;
        else
          neg_r <= q_r;
      end
      // Bypass passes the input clock; a glitch is possible on switch
      assign div_clk[g] = ctr[g].bypass ? hclk :
                          ctr[g].odd ? (q_r & neg_r) : q_r;
    end
  endgenerate

  // ==========================================================
  // AHB-Lite slave, zero wait states, read data fetched early
  logic        wr_pend_r, wr_pend_nxt;
  logic [7:0]  wr_addr_r, wr_addr_nxt;
  logic [31:0] rdata_nxt;
  logic        ctrl_en_nxt, addr_ok, wr_do;
  logic [2:0]  aidx;

  assign addr_ok  = hsel & hready & htrans[1];
  assign wr_do    = wr_pend_r;
  assign sw_upd   = wr_do & (wr_addr_r == ADDR_CTRL) & hwdata[CTRL_UPD_BIT];
  assign clr_done = wr_do & (wr_addr_r == ADDR_STATUS)
                    & hwdata[STAT_DONE_BIT];
  assign aidx     = 3'((haddr - ADDR_ACTIVE0) >> 2);

  always_comb begin
    wr_pend_nxt = addr_ok & hwrite;
    wr_addr_nxt = haddr;
    ctrl_en_nxt = ctrl_en_r;
    rdata_nxt   = hrdata;
    if (wr_do && wr_addr_r == ADDR_CTRL)
      ctrl_en_nxt = hwdata[CTRL_EN_BIT];
    if (addr_ok && !hwrite) begin
      rdata_nxt = 32'h0000_0000;
      if (haddr == ADDR_CTRL)
        rdata_nxt[CTRL_EN_BIT] = ctrl_en_r;
      else if (haddr == ADDR_STATUS) begin
        rdata_nxt[BCNT_W-1:0]   = bcnt_r;
        rdata_nxt[STAT_FULL_BIT] = full;
        rdata_nxt[STAT_DONE_BIT] = done_r;
      end else if (haddr >= ADDR_ACTIVE0
                   && (haddr - ADDR_ACTIVE0) < 8'(4 * NUM_ACTIVE)
                   && haddr[1:0] == 2'b00) begin
        rdata_nxt = 32'(CHAIN_LEN'(active_r) >> (32 * aidx));
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      ctrl_en_r <= CTRL_EN_RST;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      ctrl_en_r <= ctrl_en_nxt;
      hrdata    <= rdata_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

// file: src/pllsc_pkg.sv
// Constants and types for the loop reconfiguration scan chain.
// Assumes one 40 MHz bus clock and a 32-bit AHB-Lite register bus.
package pllsc_pkg;

  // ==========================================================
  // Chain geometry
  localparam int CHAIN_LEN  = 144;
  localparam int CNT_W      = 16;
  localparam int HALF_W     = 8;
  localparam int CTR_BITS   = 18;
  localparam int SET_BITS   = 9;
  localparam int NUM_OUT    = 5;
  localparam int BCNT_W     = 8;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_ACTIVE0 = 8'h10;
  localparam int         NUM_ACTIVE   = 5;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_UPD_BIT    = 1;
  localparam int STAT_FULL_BIT   = 8;
  localparam int STAT_DONE_BIT   = 9;
  localparam logic CTRL_EN_RST   = 1'b1;
  localparam logic [143:0] ACTIVE_RST = 144'h0;

  // ==========================================================
  // One counter: low count sits in the bits shifted in first
  typedef struct packed {
    logic              odd;
    logic              bypass;
    logic [HALF_W-1:0] high;
    logic [HALF_W-1:0] low;
  } pllsc_ctr_t;

  // Whole chain; the last field listed sits at bit 0
  typedef struct packed {
    logic [SET_BITS-1:0] loop_filter;
    logic [SET_BITS-1:0] charge_pump;
    pllsc_ctr_t          ref_div;
    pllsc_ctr_t          fb_div;
    pllsc_ctr_t          output_counter_0;
    pllsc_ctr_t          output_counter_1;
    pllsc_ctr_t          output_counter_2;
    pllsc_ctr_t          output_counter_3;
    pllsc_ctr_t          output_counter_4;
  } pllsc_chain_t;

  // Serial pins from the controller
  typedef struct packed {
    logic clk;
    logic ena;
    logic data;
    logic update;
  } pllsc_scan_t;

endpackage

// file: tb/pllsc_chk.sv
// Checker for pllsc_top, sees its ports only.
// Assumes hready is tied to hreadyout.
`timescale 1ns/1ps
module pllsc_chk
  import pllsc_pkg::*;
(
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [7:0]          haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic [31:0]         hwdata,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire pllsc_scan_t         scan_in,
  input wire logic [CNT_W+1:0]    fb_div,
  input wire logic [CNT_W+1:0]    ref_div,
  input wire logic [SET_BITS-1:0] charge_pump,
  input wire logic [SET_BITS-1:0] loop_filter
);
  // ========
  // Cycles since the last update request
  logic       wr_ctl_r;
  logic [3:0] since_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctl_r <= 1'b0;
      since_r  <= 4'hF;
    end else begin
      wr_ctl_r <= hsel && hready && htrans[1] && hwrite
                  && haddr == ADDR_CTRL;
      if (scan_in.update || (wr_ctl_r && hwdata[CTRL_UPD_BIT]))
        since_r <= 4'h0;
      else if (since_r != 4'hF)
        since_r <= since_r + 4'h1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_unmapped;
    hsel && hready && htrans[1] && !hwrite && haddr == 8'h08;
  endsequence
  sequence rd_status;
    hsel && hready && htrans[1] && !hwrite && haddr == ADDR_STATUS;
  endsequence
  sequence rd_ctrl;
    hsel && hready && htrans[1] && !hwrite && haddr == ADDR_CTRL;
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_unmapped_zero: assert property (rd_unmapped |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_set_hold: assert property (
    $changed({fb_div, ref_div, charge_pump, loop_filter})
    |-> since_r <= 4'h8)
    else $error("settings changed without update");
  a_count_limit: assert property (
    rd_status |=> hrdata[7:0] <= 8'(CHAIN_LEN))
    else $error("bit count above chain length");
  a_full_match: assert property (
    rd_status |=> hrdata[STAT_FULL_BIT] == (hrdata[7:0] == 8'(CHAIN_LEN)))
    else $error("full flag disagrees with count");
  a_ctrl_bits: assert property (rd_ctrl |=> hrdata[31:1] == 31'h0)
    else $error("control read shows more than enable");
endmodule
bind pllsc_top pllsc_chk u_pllsc_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
  .scan_in, .fb_div, .ref_div, .charge_pump, .loop_filter);

// file: tb/pllsc_ctl_model.sv
// Reconfiguration controller model driving the scan pins.
// Assumes hclk paces it; clock parks low between frames.
`timescale 1ns/1ps
module pllsc_ctl_model
  import pllsc_pkg::*;
(
  input wire logic hclk,
  output pllsc_scan_t scan
);
  initial scan = '0;
  task automatic hold(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Chain bit 0 goes first, bit n-1 last
  task automatic load(input logic [CHAIN_LEN-1:0] c, input int n);
    hold(1);
    for (int i = 0; i < n; i++) begin
      scan.ena  <= 1'b1;
      scan.data <= c[i];
      scan.clk  <= 1'b0;
      hold(4);
      scan.clk <= 1'b1;
      hold(4);
    end
    // Released data line shows the inverse, never a stale bit
    scan.clk  <= 1'b0;
    scan.ena  <= 1'b0;
    scan.data <= ~c[n-1];
    hold(4);
  endtask
  task automatic update();
    scan.update <= 1'b1;
    hold(4);
    scan.update <= 1'b0;
    hold(8);
  endtask
endmodule

// file: tb/tb_pllsc_top.sv
// Self-checking bench for pllsc_top.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ps
module tb_pllsc_top;
  import pllsc_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 0, hrdata, rd;
  logic hreadyout, hresp;
  wire logic hready = hreadyout;
  pllsc_scan_t scan_in;
  logic [CNT_W+1:0] fb_div, ref_div;
  logic [SET_BITS-1:0] charge_pump, loop_filter;
  logic [NUM_OUT-1:0] div_clk;
  int failures = 0, tests_run = 0;
  pllsc_chain_t c1, c2;
  always #12.5 hclk = ~hclk;
  pllsc_top u_pllsc_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
    .scan_in, .fb_div, .ref_div, .charge_pump, .loop_filter, .div_clk);
  pllsc_ctl_model u_pllsc_ctl_model (.hclk, .scan(scan_in));
  task automatic wrap_up();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [143:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= a;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  // Samples each half cycle; checks period and 50 percent duty
  task automatic chk_wave(input int idx, input int h);
    logic [23:0] v;
    logic        ok;
    ok = 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(hclk);
      #2 v[i] = div_clk[idx];
    end
    for (int i = 0; i + h < 24; i++)
      if (v[i] !== v[i+h] || v[i] === v[i+h/2]) ok = 1'b0;
    cmp(144'(ok), 144'h1, "divided clock shape");
    @(posedge hclk);
  endtask
  task automatic t_load();
    logic [159:0] e;
    e = {16'h0, c1};
    u_pllsc_ctl_model.load(c1, 144);
    bus(0, ADDR_STATUS, 0);
    cmp(rd, 32'h190, "count before update");
    cmp(fb_div, 0, "early settings");
    u_pllsc_ctl_model.update();
    cmp(fb_div, c1.fb_div, "fb");
    cmp(ref_div, c1.ref_div, "ref");
    cmp(charge_pump, c1.charge_pump, "cp");
    cmp(loop_filter, c1.loop_filter, "lf");
    for (int k = 0; k < NUM_ACTIVE; k++) begin
      bus(0, ADDR_ACTIVE0 + 8'(4 * k), 0);
      cmp(rd, e[32*k +: 32], "active word");
    end
    bus(0, ADDR_STATUS, 0);
    cmp(rd, 32'h200, "done flag");
    $display("load test done");
  endtask
  task automatic t_regs();
    bus(0, ADDR_CTRL, 0);
    cmp(rd, 32'h1, "ctrl reset");
    bus(0, 8'h08, 0);
    cmp(rd, 32'h0, "unmapped");
    $display("register test done");
  endtask
  task automatic t_div();
    chk_wave(4, 2);
    chk_wave(3, 6);
    chk_wave(2, 8);
    $display("divider test done");
  endtask
  task automatic t_update();
    u_pllsc_ctl_model.load(c2, 143);
    u_pllsc_ctl_model.update();
    cmp(fb_div, c1.fb_div, "partial load");
    cmp(loop_filter, c1.loop_filter, "partial lf");
    u_pllsc_ctl_model.load(c2, 144);
    bus(1, ADDR_CTRL, 32'h3);
    repeat (8) @(posedge hclk);
    cmp(loop_filter, c2.loop_filter, "sw update");
    $display("update test done");
  endtask
  // Disabled scan takes no bits; done flag clears on a written one
  task automatic t_disable();
    bus(1, ADDR_CTRL, 32'h0);
    u_pllsc_ctl_model.load(c1, 144);
    u_pllsc_ctl_model.update();
    cmp(fb_div, c2.fb_div, "update while disabled");
    bus(0, ADDR_STATUS, 0);
    cmp(rd, 32'h200, "no shifts while disabled");
    bus(1, ADDR_STATUS, 32'h200);
    bus(0, ADDR_STATUS, 0);
    cmp(rd, 32'h0, "done cleared");
    bus(1, ADDR_CTRL, 32'h1);
    bus(0, ADDR_CTRL, 0);
    cmp(rd, 32'h1, "enable back");
    $display("disable test done");
  endtask
  // Mid-run reset must drop fb_div and loop_filter and restore the registers
  task automatic t_reset();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    cmp(fb_div, 0, "fb after reset");
    cmp(loop_filter, 0, "lf after reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, ADDR_STATUS, 0);
    cmp(rd, 32'h0, "status after reset");
    bus(0, ADDR_CTRL, 0);
    cmp(rd, 32'h1, "ctrl after reset");
    $display("reset test done");
  endtask
  initial begin
    c1 = '0;
    c1.output_counter_4.bypass = 1'b1;
    c1.output_counter_3 = 18'h20201;
    c1.output_counter_2 = 18'h00202;
    c1.fb_div = 18'h2A5C3;
    c1.ref_div = 18'h15A3C;
    c1.charge_pump = 9'h1A5;
    c1.loop_filter = 9'h14B;
    c2 = ~c1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_load();
    t_div();
    t_update();
    t_disable();
    t_reset();
    wrap_up();
  end
endmodule
